/* File: rtl/ctch_map.vh */
`ifndef CTCH_MAP_VH
`define CTCH_MAP_VH
// Register indices; byte address is four times the index
`define CTCH_IDX_NOOP 8'h00
`define CTCH_IDX_FATAL 8'h20
`define CTCH_IDX_WARN 8'h21
`define CTCH_IDX_SRQT 8'h28
`define CTCH_IDX_CHAN_LO 8'h30
`define CTCH_IDX_GRID 8'h34
`define CTCH_IDX_FCF_THZ 8'h35
`define CTCH_IDX_FCF_GHZ 8'h36
`define CTCH_IDX_CHAN_HI 8'h65
`define CTCH_IDX_GRID_FINE 8'h66
`define CTCH_IDX_FCF_MHZ 8'h67
// Block-local registers
`define CTCH_IDX_RESP 8'h70
`define CTCH_IDX_IRQ_STAT 8'h71
`define CTCH_IDX_IRQ_MASK 8'h72
`define CTCH_IDX_TUNE_CMD 8'h73
// Fields
`define CTCH_PEND_BIT 8
`define CTCH_ERR_LSB 0
`define CTCH_EXF_CODE 4'h8
`define CTCH_XEL_BIT 0
`define CTCH_SRQT_RESET 16'h0001
`define CTCH_STS_OK 2'h0
`define CTCH_STS_CP 2'h3
// Interrupt status bits
`define CTCH_IRQ_DONE 0
`define CTCH_IRQ_FAIL 1
`define CTCH_IRQ_W 2
`define CTCH_TUNE_DONE_BIT 0
`define CTCH_TUNE_FAIL_BIT 1
`endif

/* File: rtl/ctch_handler.v */
`timescale 1ns/10ps
`default_nettype none
`include "ctch_map.vh"
// Register window, one 16-bit register per 32-bit word
//   0x00  No-op report: bit 8 pending, bits 3:0 error field
//   0x20  Fatal status: bit 0 execution error latch
//   0x21  Warning status: bit 0 execution error latch
//   0x28  Service request triggers: bit 0 lets the latch raise the request
//   0x30  Channel low word; a write starts tuning
//   0x34  Coarse grid spacing
//   0x35  First channel frequency, THz part
//   0x36  First channel frequency, GHz part
//   0x65  Channel high word; a write only stores it
//   0x66  Fine grid spacing
//   0x67  First channel frequency, MHz part
//   0x70  Echo of the last write answer
//   0x71  Interrupt status: bit 0 done, bit 1 fail; read clears
//   0x72  Interrupt mask, same layout as the status
//   0x73  Reserved, reads zero
//
// Bus timing
//   A request is taken on the edge that sees cyc and stb high
//   while ack and err are low.
//   Ack or err follows one clock later and lasts one cycle.
//   The status code stays on the bus until the next mapped request is
//   taken; read data and the write echo clear on the edge after ack.
//   Unmapped indices answer with err and change nothing.
//   Writes need byte lanes 0 and 1; other lane sets are acked
//   and dropped, so a partial write never splits a register.
//
// Status codes on resp_status_o
//   0  OK, the command completed at once
//   3  Command pending, a tuning run was launched
//
// Channel pairing
//   The high word waits in its own register.
//   The low word write latches both halves into channel_o in
//   the same edge, so the tuner never sees a half-updated value.
//   Writing the high word while a run is pending does not
//   disturb the run already under way.
//
// Tuning run
//   Only one pending slot exists, bit 8 of the no-op report.
//   The run lasts TUNE_CYCLES clocks unless a failure ends it.
//   A new low word write while pending restarts the count;
//   the host sees no second slot for it.
//   A failure pulse is ignored when no run is pending, so a
//   stray fail level after the run cannot raise the latch.
//   The error field is cleared at each new launch, so a stale
//   failure code never survives into a fresh run.
//
// Error latch and service request
//   A failure sets bit 0 in both status registers at once.
//   Writing one to that bit clears the register written;
//   a failure in the same cycle wins over the clear.
//   The service request follows the fatal copy of the latch
//   and its trigger enable, and rises on the failure edge.
//   Clearing only the warning copy leaves the request standing.
//
// Interrupt
//   Done and fail events set sticky status bits.
//   A status read clears them, but an event in the same cycle
//   survives the clear.
//   irq_o is one cycle behind the status and mask registers.
//
// Reset
//   All outputs clear; the trigger enable for the latch is set.
//   The first request may follow on the first edge after reset.
//
// Limitations
//   The grid and frequency registers are stored only; the
//   tuner outside this block does the frequency arithmetic.
//   Nothing here checks that the laser output is off while the
//   channel map changes; the host must keep to that.
//   The counter is 32 bits wide so that long settling times fit
//   without a change of port widths.
//
// Trade-offs
//   Answers are registered, costing one cycle of latency but
//   keeping every output straight off a flip-flop.
//   The read mux decodes the index every cycle; it costs a few
//   gates but keeps the answer path short.
// Channel tuning command handler behind a classic Wishbone slave
module ctch_handler #(
  parameter TUNE_CYCLES = 64
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [9:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire tune_fail_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg err_o,
  output reg [1:0] resp_status_o,
  output reg tune_busy_o,
  output reg [31:0] channel_o,
  output reg service_request_o,
  output reg irq_o
);

  // Word index from a byte address
  function [7:0] widx(input [9:0] a);
    widx = a[9:2];
  endfunction

  reg [15:0] coarse_grid_spacing_reg;
  reg [15:0] fine_grid_spacing_reg;
  reg [15:0] first_freq_thz_reg;
  reg [15:0] first_freq_ghz_reg;
  reg [15:0] first_freq_mhz_reg;
  reg [15:0] channel_high_word_reg;
  reg [15:0] channel_low_word_reg;
  reg [15:0] fatal_status_reg;
  reg [15:0] warning_status_reg;
  reg [15:0] service_request_triggers_reg;
  reg pending_reg;
  reg [3:0] err_field_reg;
  reg [31:0] tune_cnt_reg;
  reg [`CTCH_IRQ_W-1:0] irq_stat_reg;
  reg [`CTCH_IRQ_W-1:0] irq_mask_reg;
  reg [15:0] last_echo_reg;

  wire req = cyc_i & stb_i & ~ack_o & ~err_o;
  wire [7:0] idx = widx(adr_i);
  wire wr = req & we_i & sel_i[0] & sel_i[1];
  wire rd = req & ~we_i;
  // Tuning starts only on the low channel word write
  wire start = wr && idx == `CTCH_IDX_CHAN_LO;
  wire finish = pending_reg && tune_cnt_reg == 32'h0000_0001;
  wire fail = pending_reg && tune_fail_i;
  wire mapped = idx == `CTCH_IDX_NOOP || idx == `CTCH_IDX_FATAL ||
    idx == `CTCH_IDX_WARN || idx == `CTCH_IDX_SRQT || idx == `CTCH_IDX_CHAN_LO ||
    idx == `CTCH_IDX_GRID || idx == `CTCH_IDX_FCF_THZ ||
    idx == `CTCH_IDX_FCF_GHZ || idx == `CTCH_IDX_CHAN_HI ||
    idx == `CTCH_IDX_GRID_FINE || idx == `CTCH_IDX_FCF_MHZ ||
    idx == `CTCH_IDX_RESP || idx == `CTCH_IDX_IRQ_STAT ||
    idx == `CTCH_IDX_IRQ_MASK || idx == `CTCH_IDX_TUNE_CMD;
  wire [15:0] noop_val = {7'h00, pending_reg, 4'h0, err_field_reg};
  wire [`CTCH_IRQ_W-1:0] irq_ev = {fail, finish};
  wire [15:0] trig = service_request_triggers_reg;
  wire xel_now = fatal_status_reg[`CTCH_XEL_BIT] | fail;

  // Read mux, combinational
  reg [15:0] rdata;
  always @* begin
    case (idx)
      `CTCH_IDX_NOOP: rdata = noop_val;
      `CTCH_IDX_FATAL: rdata = fatal_status_reg;
      `CTCH_IDX_WARN: rdata = warning_status_reg;
      `CTCH_IDX_SRQT: rdata = service_request_triggers_reg;
      `CTCH_IDX_CHAN_LO: rdata = channel_low_word_reg;
      `CTCH_IDX_GRID: rdata = coarse_grid_spacing_reg;
      `CTCH_IDX_FCF_THZ: rdata = first_freq_thz_reg;
      `CTCH_IDX_FCF_GHZ: rdata = first_freq_ghz_reg;
      `CTCH_IDX_CHAN_HI: rdata = channel_high_word_reg;
      `CTCH_IDX_GRID_FINE: rdata = fine_grid_spacing_reg;
      `CTCH_IDX_FCF_MHZ: rdata = first_freq_mhz_reg;
      `CTCH_IDX_RESP: rdata = last_echo_reg;
      `CTCH_IDX_IRQ_STAT: rdata = {14'h0000, irq_stat_reg};
      `CTCH_IDX_IRQ_MASK: rdata = {14'h0000, irq_mask_reg};
      `CTCH_IDX_TUNE_CMD: rdata = 16'h0000;
      default: rdata = 16'h0000;
    endcase
  end

  // Bus answer: one cycle after the request, ack dropped next cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      resp_status_o <= `CTCH_STS_OK;
      last_echo_reg <= 16'h0000;
    end else begin
      ack_o <= req & mapped;
      err_o <= req & ~mapped;
      if (req & mapped) begin
        if (start) begin
          // Pending answer carries the pending slot bit
          resp_status_o <= `CTCH_STS_CP;
          dat_o <= {16'h0000, 16'h0001 << `CTCH_PEND_BIT};
          last_echo_reg <= 16'h0001 << `CTCH_PEND_BIT;
        end else if (wr) begin
          // Configuration writes complete at once and echo data
          resp_status_o <= `CTCH_STS_OK;
          dat_o <= {16'h0000, dat_i[15:0]};
          last_echo_reg <= dat_i[15:0];
        end else begin
          resp_status_o <= `CTCH_STS_OK;
          dat_o <= {16'h0000, rdata};
        end
      end else if (!req) begin
        dat_o <= 32'h0000_0000;
      end
    end
  end

  // Configuration and channel storage; host keeps laser off meanwhile
  always @(posedge clk_i) begin
    if (rst_i) begin
      coarse_grid_spacing_reg <= 16'h0000;
      fine_grid_spacing_reg <= 16'h0000;
      first_freq_thz_reg <= 16'h0000;
      first_freq_ghz_reg <= 16'h0000;
      first_freq_mhz_reg <= 16'h0000;
      channel_high_word_reg <= 16'h0000;
      channel_low_word_reg <= 16'h0000;
      service_request_triggers_reg <= `CTCH_SRQT_RESET;
      irq_mask_reg <= {`CTCH_IRQ_W{1'b0}};
      channel_o <= 32'h0000_0000;
    end else begin
      if (wr) begin
        case (idx)
          `CTCH_IDX_GRID: coarse_grid_spacing_reg <= dat_i[15:0];
          `CTCH_IDX_GRID_FINE: fine_grid_spacing_reg <= dat_i[15:0];
          `CTCH_IDX_FCF_THZ: first_freq_thz_reg <= dat_i[15:0];
          `CTCH_IDX_FCF_GHZ: first_freq_ghz_reg <= dat_i[15:0];
          `CTCH_IDX_FCF_MHZ: first_freq_mhz_reg <= dat_i[15:0];
          `CTCH_IDX_CHAN_HI: channel_high_word_reg <= dat_i[15:0];
          `CTCH_IDX_CHAN_LO: channel_low_word_reg <= dat_i[15:0];
          `CTCH_IDX_SRQT: service_request_triggers_reg <= dat_i[15:0];
          `CTCH_IDX_IRQ_MASK: irq_mask_reg <= dat_i[`CTCH_IRQ_W-1:0];
          default: channel_o <= channel_o;
        endcase
      end
      // Full 32-bit target latched from both halves at tuning start
      if (start) begin
        channel_o <= {channel_high_word_reg, dat_i[15:0]};
      end
    end
  end

  // Tuning operation: pending bit held until done or failed
  always @(posedge clk_i) begin
    if (rst_i) begin
      pending_reg <= 1'b0;
      tune_cnt_reg <= 32'h0000_0000;
      err_field_reg <= 4'h0;
      tune_busy_o <= 1'b0;
    end else begin
      if (start) begin
        pending_reg <= 1'b1;
        tune_cnt_reg <= TUNE_CYCLES;
        err_field_reg <= 4'h0;
        tune_busy_o <= 1'b1;
      end else if (fail) begin
        // Failure ends the operation with the failure code
        pending_reg <= 1'b0;
        err_field_reg <= `CTCH_EXF_CODE;
        tune_cnt_reg <= 32'h0000_0000;
        tune_busy_o <= 1'b0;
      end else if (finish) begin
        pending_reg <= 1'b0;
        tune_cnt_reg <= 32'h0000_0000;
        tune_busy_o <= 1'b0;
      end else if (pending_reg) begin
        tune_cnt_reg <= tune_cnt_reg - 32'h0000_0001;
      end
    end
  end

  // Error latch in both status registers; a write of one clears it,
  // but a failure in the same cycle wins
  always @(posedge clk_i) begin
    if (rst_i) begin
      fatal_status_reg <= 16'h0000;
      warning_status_reg <= 16'h0000;
    end else begin
      if (fail) begin
        fatal_status_reg[`CTCH_XEL_BIT] <= 1'b1;
        warning_status_reg[`CTCH_XEL_BIT] <= 1'b1;
      end else if (wr && idx == `CTCH_IDX_FATAL && dat_i[`CTCH_XEL_BIT]) begin
        fatal_status_reg[`CTCH_XEL_BIT] <= 1'b0;
      end else if (wr && idx == `CTCH_IDX_WARN && dat_i[`CTCH_XEL_BIT]) begin
        warning_status_reg[`CTCH_XEL_BIT] <= 1'b0;
      end
    end
  end

  // Service request and interrupt; read of status clears, events win
  always @(posedge clk_i) begin
    if (rst_i) begin
      service_request_o <= 1'b0;
      irq_stat_reg <= {`CTCH_IRQ_W{1'b0}};
      irq_o <= 1'b0;
    end else begin
      service_request_o <= xel_now & trig[`CTCH_XEL_BIT];
      if (rd && idx == `CTCH_IDX_IRQ_STAT) begin
        irq_stat_reg <= irq_ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_ev;
      end
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule
`default_nettype wire

/* File: tb/ctch_handler_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// Watches the register port and the tuning outputs of the handler
module ctch_handler_sva #(
  parameter TUNE_CYCLES = 64
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [9:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire tune_fail_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire err_o,
  input wire [1:0] resp_status_o,
  input wire tune_busy_o,
  input wire [31:0] channel_o,
  input wire service_request_o,
  input wire irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] busy_cnt_reg;
  wire wr_ok = cyc_i & stb_i & ~ack_o & ~err_o & we_i & (sel_i[1:0] == 2'h3);
  wire [7:0] ix = adr_i[9:2];
  wire cfg = ix inside {8'h34, 8'h35, 8'h36, 8'h66, 8'h67};
  // Age of the current tuning run; a restart keeps counting, which only loosens the check
  always @(posedge clk_i) busy_cnt_reg <= tune_busy_o ? busy_cnt_reg + 8'h01 : 8'h00;
  a_cfg_echo: assert property (wr_ok && cfg |=> ack_o && resp_status_o == 2'h0 &&
    dat_o == {16'h0000, $past(dat_i[15:0])}) else $error("config write not echoed");
  a_low_tunes: assert property (wr_ok && ix == 8'h30 |=>
    tune_busy_o && channel_o[15:0] == $past(dat_i[15:0])) else $error("tuning not started");
  a_pend_code: assert property (wr_ok && ix == 8'h30 |=>
    resp_status_o == 2'h3 && dat_o == 32'h00000100) else $error("pending reply wrong");
  a_high_stores: assert property (wr_ok && ix == 8'h65 && !tune_busy_o |=>
    resp_status_o == 2'h0 && !tune_busy_o) else $error("high word write misbehaved");
  a_busy_holds: assert property (tune_busy_o && !tune_fail_i && busy_cnt_reg < TUNE_CYCLES - 2
    |=> tune_busy_o) else $error("pending bit dropped early");
  a_tune_ends: assert property ($rose(tune_busy_o) |-> ##[1:80] !tune_busy_o)
    else $error("pending bit never cleared");
  a_fail_stop: assert property (tune_busy_o && tune_fail_i |=> !tune_busy_o)
    else $error("failure left operation pending");
  a_srq_raise: assert property (tune_busy_o && tune_fail_i |-> ##2 service_request_o)
    else $error("service request not raised");
  a_ack_once: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  cover property ($rose(tune_busy_o));
  cover property ($rose(service_request_o));
  cover property (err_o);
  cover property ($rose(irq_o));
endmodule
bind ctch_handler ctch_handler_sva #(.TUNE_CYCLES(TUNE_CYCLES)) ctch_handler_sva_i(.clk_i, .rst_i,
  .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .tune_fail_i, .dat_o, .ack_o, .err_o,
  .resp_status_o, .tune_busy_o, .channel_o, .service_request_o, .irq_o);
`default_nettype wire

/* File: tb/ctch_tune_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Tuning engine stand-in: when armed, reports a failure three cycles into a run
module ctch_tune_model (
  input wire logic clk_i,
  input wire logic tune_busy_i,
  input wire logic arm_i,
  output var logic tune_fail_o
);
  logic [3:0] cnt_reg = 4'h0;
  initial tune_fail_o = 1'b0;
  // Failure only while a run is pending, as a real engine would
  always @(posedge clk_i) begin
    cnt_reg <= tune_busy_i ? cnt_reg + 4'h1 : 4'h0;
    tune_fail_o <= arm_i && tune_busy_i && cnt_reg == 4'h2;
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, arm = 0, re, fail;
  logic [9:0] adr = 0;
  logic [3:0] sel = 4'hf, wsel = 4'hf;
  logic [31:0] dat = 0, rd, dat_o, channel_o;
  logic [1:0] rs, resp_status_o;
  logic ack_o, err_o, tune_busy_o, service_request_o, irq_o;
  logic [7:0] cfg [5] = '{8'h34, 8'h66, 8'h35, 8'h36, 8'h67};
  int errors = 0, n_checks = 0, cycles = 0, n;
  initial forever #4 clk_i = ~clk_i;
  ctch_handler #(.TUNE_CYCLES(8)) ctch_handler_i(.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .tune_fail_i(fail), .dat_o, .ack_o,
    .err_o, .resp_status_o, .tune_busy_o, .channel_o, .service_request_o, .irq_o);
  ctch_tune_model ctch_tune_model_i(.clk_i, .tune_busy_i(tune_busy_o), .arm_i(arm),
    .tune_fail_o(fail));
  task automatic tally_and_finish;
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One classic cycle; the answer is taken at the edge that shows ack or err
  task automatic wb(input logic w, input logic [7:0] ix, input logic [15:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= {ix, 2'b00}; dat <= {16'h0000, d};
    sel <= wsel;
    do @(posedge clk_i); while (!(ack_o | err_o));
    rd = dat_o; rs = resp_status_o; re = err_o;
    cyc <= 0; stb <= 0;
    @(posedge clk_i);
  endtask
  task automatic poll;
    n = 0;
    do wb(0, 8'h00, 16'h0000); while (rd[8] && ++n < 30);
  endtask
  // A hang ends here instead of running forever
  always @(posedge clk_i) if (++cycles == 5000) begin
    errors++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, 8'h28, 0); chk("trig", rd, 32'h1);
    // Laser output is still off here, so the map may be changed
    foreach (cfg[i]) begin
      wb(1, cfg[i], 16'h0100 + i); chk("echo", {rs, rd}, {2'h0, 32'h0100 + i});
      wb(0, cfg[i], 0); chk("rdbk", rd, 32'h0100 + i);
    end
    wb(1, 8'h72, 16'h0003);
    wb(1, 8'h65, 16'h0bb3); chk("hi", {rs, tune_busy_o}, 3'h0);
    wb(1, 8'h30, 16'hcf15); chk("lo", {rs, rd}, {2'h3, 32'h100});
    chk("chan", channel_o, 32'h0bb3cf15);
    wb(0, 8'h00, 0); chk("pend", rd, 32'h100);
    poll; chk("done", rd, 32'h0);
    chk("irq", irq_o, 1);
    wb(0, 8'h71, 0); chk("ists", rd[0], 1);
    repeat (2) @(posedge clk_i); chk("irqclr", irq_o, 0);
    // Failure mid-run: pending bit drops with the failure code
    arm <= 1;
    wb(1, 8'h30, 16'h0002);
    poll; chk("exf", rd, 32'h8);
    arm <= 0;
    wb(0, 8'h20, 0); chk("fatal", rd[0], 1);
    wb(0, 8'h21, 0); chk("warn", rd[0], 1);
    chk("srq", service_request_o, 1);
    wb(0, 8'h71, 0); chk("ifail", rd[1], 1);
    wb(1, 8'h20, 16'h0001); wb(1, 8'h21, 16'h0001);
    repeat (2) @(posedge clk_i); chk("srqclr", service_request_o, 0);
    // Masked completion must stay quiet
    wb(1, 8'h72, 16'h0000); wb(1, 8'h30, 16'h0003); poll;
    chk("mask", irq_o, 0);
    wb(0, 8'h10, 0); chk("unmapped", re, 1);
    // Write without both low byte lanes is acked but dropped
    wsel = 4'hc;
    wb(1, 8'h34, 16'hdead); chk("selack", re, 0);
    wsel = 4'hf;
    wb(0, 8'h34, 0); chk("selmask", rd, 32'h100);
    tally_and_finish;
  end
endmodule
`default_nettype wire
